// ==== rtl/acr_config_reg.sv ====
`timescale 1ns/1ps
`default_nettype none
module acr_config_reg
  import acr_pkg::*;
#(
  parameter int unsigned CONV_NOCHOP   = CONV_NOCHOP_CYC,
  parameter int unsigned SETTLE_NOCHOP = SETTLE_NOCHOP_CYC,
  parameter int unsigned CONV_CHOP     = CONV_CHOP_CYC,
  parameter int unsigned SETTLE_CHOP   = SETTLE_CHOP_CYC
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       sclk,
  input  wire logic       csN,
  input  wire logic       din,
  output var  logic       dout,
  output var  logic       chopEnable,
  output var  logic       referenceSourceSelect,
  output var  logic       firstReferencePairActive,
  output var  logic       secondReferencePairActive,
  output var  logic       pseudoInputMode,
  output var  logic       shortSelect,
  output var  logic       temperatureSelect,
  output var  logic [7:0] channelEnableBits,
  output var  logic       burnoutEnable,
  output var  logic       referenceMissingDetectEnable,
  output var  logic       bufferEnable,
  output var  logic       unipolarMode,
  output var  logic [2:0] gainCode,
  output var  logic       settled,
  output var  logic       conversionValid
);

  // reload values for the settling/conversion timer
  function automatic logic [TIMER_W-1:0] settleLoad(input logic chop);
    settleLoad = chop ? TIMER_W'(SETTLE_CHOP - 1) : TIMER_W'(SETTLE_NOCHOP - 1);
  endfunction

  function automatic logic [TIMER_W-1:0] convLoad(input logic chop);
    convLoad = chop ? TIMER_W'(CONV_CHOP - 1) : TIMER_W'(CONV_NOCHOP - 1);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: the first stage feeds only the second
  logic [2:0] sclkSync_q;
  logic [1:0] csNSync_q;
  logic [1:0] dinSync_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      sclkSync_q <= 3'h7;
      csNSync_q  <= 2'h3;
      dinSync_q  <= 2'h0;
    end else begin
      sclkSync_q <= {sclkSync_q[1:0], sclk};
      csNSync_q  <= {csNSync_q[0], csN};
      dinSync_q  <= {dinSync_q[0], din};
    end
  end

  wire logic sclkRise = sclkSync_q[1] & ~sclkSync_q[2];
  wire logic sclkFall = ~sclkSync_q[1] & sclkSync_q[2];
  wire logic selected = ~csNSync_q[1];
  wire logic dinS     = dinSync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // serial framing: command byte, then 24 data bits
  acr_ser_t          ser_q;
  logic [4:0]        bitCnt_q;
  logic [6:0]        cmdShift_q;
  logic [22:0]       inShift_q;
  logic [23:0]       outShift_q;
  logic              readMode_q;
  logic [23:0]       cfg_q;
  logic              dout_q;

  wire logic [7:0]  cmdWord   = {cmdShift_q, dinS};
  wire logic        cmdDone   = (ser_q == SER_CMD) && sclkRise && (bitCnt_q == CMD_LAST_BIT);
  wire logic        cmdHit    = ~cmdWord[CMD_BIT_WEN] && (cmdWord[CMD_SEL_HI:CMD_SEL_LO] == REG_SEL_CFG);
  wire logic        dataLast  = (ser_q == SER_DATA) && sclkRise && (bitCnt_q == DATA_LAST_BIT);
  wire logic        commit    = selected && dataLast && ~readMode_q;
  wire logic [23:0] newWord   = {inShift_q, dinS};  // bit 23 arrived first

  // frame sequencing; a raised chip select abandons the frame without a write
  always_ff @(posedge mclk) begin
    if (rst || !selected) begin
      ser_q    <= SER_CMD;
      bitCnt_q <= 5'h00;
    end else if (sclkRise) begin
      unique case (ser_q)
        SER_CMD: begin
          bitCnt_q <= cmdDone ? 5'h00 : bitCnt_q + 5'h01;
          if (cmdDone) begin
            ser_q <= cmdHit ? SER_DATA : SER_IDLE;
          end
        end
        SER_DATA: begin
          bitCnt_q <= bitCnt_q + 5'h01;
          if (dataLast) begin
            ser_q <= SER_IDLE;
          end
        end
        SER_IDLE: bitCnt_q <= 5'h00;
      endcase
    end
  end

  // shift registers for command, write data and read data
  always_ff @(posedge mclk) begin
    if (rst) begin
      cmdShift_q <= 7'h00;
      inShift_q  <= 23'h000000;
      outShift_q <= 24'h000000;
      readMode_q <= 1'b0;
      dout_q     <= 1'b0;
    end else if (!selected) begin
      dout_q <= 1'b0;
    end else begin
      if (sclkRise && ser_q == SER_CMD) begin
        cmdShift_q <= cmdWord[6:0];
      end
      if (cmdDone) begin
        readMode_q <= cmdWord[CMD_BIT_RD];
        outShift_q <= cfg_q;
      end
      if (sclkRise && ser_q == SER_DATA) begin
        inShift_q <= newWord[22:0];
      end
      // read data changes on the falling edge so the host samples it on the rise
      if (sclkFall && ser_q == SER_DATA && readMode_q) begin
        dout_q     <= outShift_q[23];
        outShift_q <= {outShift_q[22:0], 1'b0};
      end else if (ser_q != SER_DATA) begin
        dout_q <= 1'b0;
      end
    end
  end

  // the register itself; reserved bits store what the host wrote, and the
  // host keeps them at zero
  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg_q <= CFG_RESET;
    end else if (commit) begin
      cfg_q <= newWord;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reference routing: both pair selects are registered so each pin comes from a flop
  logic firstRef_q;
  logic secondRef_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      firstRef_q  <= ~CFG_RESET[BIT_REF_SOURCE];
      secondRef_q <= CFG_RESET[BIT_REF_SOURCE];
    end else begin
      firstRef_q  <= ~cfg_q[BIT_REF_SOURCE];
      secondRef_q <= cfg_q[BIT_REF_SOURCE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // settling and conversion timing; any write restarts full settling
  logic [TIMER_W-1:0] timer_q;
  logic               settled_q;
  logic               convValid_q;

  wire logic chopNow = commit ? newWord[BIT_CHOP] : cfg_q[BIT_CHOP];
  wire logic expired = (timer_q == '0);

  always_ff @(posedge mclk) begin
    if (rst || commit) begin
      timer_q     <= settleLoad(rst ? CFG_RESET[BIT_CHOP] : chopNow);
      settled_q   <= 1'b0;
      convValid_q <= 1'b0;
    end else if (expired) begin
      timer_q     <= convLoad(cfg_q[BIT_CHOP]);
      settled_q   <= 1'b1;
      convValid_q <= 1'b1;
    end else begin
      timer_q     <= timer_q - TIMER_W'(1);
      convValid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from flops
  assign dout                         = dout_q;
  assign chopEnable                   = cfg_q[BIT_CHOP];
  assign referenceSourceSelect        = cfg_q[BIT_REF_SOURCE];
  assign firstReferencePairActive     = firstRef_q;
  assign secondReferencePairActive    = secondRef_q;
  assign pseudoInputMode              = cfg_q[BIT_PSEUDO];
  assign shortSelect                  = cfg_q[BIT_SHORT];
  assign temperatureSelect            = cfg_q[BIT_TEMP];
  assign channelEnableBits            = cfg_q[BIT_CH_HI:BIT_CH_LO];
  assign burnoutEnable                = cfg_q[BIT_BURN];
  assign referenceMissingDetectEnable = cfg_q[BIT_REF_DETECT];
  assign bufferEnable                 = cfg_q[BIT_BUF];
  assign unipolarMode                 = cfg_q[BIT_POL];
  assign gainCode                     = cfg_q[BIT_GAIN_HI:0];
  assign settled                      = settled_q;
  assign conversionValid              = convValid_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_writeDone;
    commit ##1 (cfg_q == $past(newWord));
  endsequence

  sequence s_readShift;
    sclkFall && ser_q == SER_DATA && readMode_q && selected;
  endsequence

  a_reset_value: assert property (@(posedge mclk) rst |=> cfg_q == 24'h000117)
    else $error("configuration not at reset value after reset");
  a_reset_fields: assert property (@(posedge mclk) $fell(rst) |-> channelEnableBits == 8'h01
    && bufferEnable && gainCode == 3'h7 && !chopEnable)
    else $error("reset field values wrong");
  a_write_commit: assert property (commit |-> s_writeDone)
    else $error("written word not stored");
  a_read_source: assert property (cmdDone && cmdHit |=> outShift_q == cfg_q)
    else $error("read shifter not loaded from register");
  a_read_msb: assert property (s_readShift |=> dout_q == $past(outShift_q[23]))
    else $error("read bit order wrong");
  a_ref_route: assert property (##1 firstReferencePairActive == !$past(cfg_q[BIT_REF_SOURCE]))
    else $error("reference pair routing wrong");
  a_ref_second: assert property (##1 secondReferencePairActive == $past(cfg_q[BIT_REF_SOURCE]))
    else $error("second reference pair routing wrong");
  a_settle_load: assert property (commit |=> timer_q == settleLoad($past(newWord[BIT_CHOP])))
    else $error("settling time not reloaded on write");
  a_no_early_valid: assert property (commit |=> (!conversionValid && !settled) [*8])
    else $error("conversion flagged during settling");
  a_conv_gap: assert property ($rose(conversionValid) |=> !conversionValid)
    else $error("conversion strobe longer than one cycle");

endmodule // acr_config_reg
`default_nettype wire

// ==== rtl/acr_pkg.sv ====
package acr_pkg;
  // register map and field layout of the converter configuration register
  localparam logic [2:0]  REG_SEL_CFG    = 3'h2;        // register select code of the configuration register
  localparam int          CFG_WIDTH      = 24;
  localparam logic [23:0] CFG_RESET      = 24'h000117;
  localparam int          BIT_CHOP       = 23;
  localparam int          BIT_RSVD22     = 22;
  localparam int          BIT_RSVD21     = 21;
  localparam int          BIT_REF_SOURCE = 20;
  localparam int          BIT_PSEUDO     = 18;
  localparam int          BIT_SHORT      = 17;
  localparam int          BIT_TEMP       = 16;
  localparam int          BIT_CH_HI      = 15;
  localparam int          BIT_CH_LO      = 8;
  localparam int          BIT_BURN       = 7;
  localparam int          BIT_REF_DETECT = 6;
  localparam int          BIT_BUF        = 4;
  localparam int          BIT_POL        = 3;
  localparam int          BIT_GAIN_HI    = 2;
  // command byte layout
  localparam int          CMD_BIT_WEN    = 7;
  localparam int          CMD_BIT_RD     = 6;
  localparam int          CMD_SEL_HI     = 5;
  localparam int          CMD_SEL_LO     = 3;
  localparam logic [4:0]  CMD_LAST_BIT   = 5'h07;
  localparam logic [4:0]  DATA_LAST_BIT  = 5'h17;
  // timing at a filter word of 96 with the fourth-order sinc filter
  localparam int          CLK_PERIOD_NS  = 4;
  localparam int          NS_PER_MS      = 1000000;
  localparam int          CONV_NOCHOP_MS = 20;
  localparam int          SETTLE_NOCHOP_MS = 80;
  localparam int          CONV_CHOP_MS   = 80;
  localparam int          SETTLE_CHOP_MS = 160;
  localparam int          CYC_PER_MS     = NS_PER_MS / CLK_PERIOD_NS;
  localparam int          CONV_NOCHOP_CYC   = CONV_NOCHOP_MS * CYC_PER_MS;
  localparam int          SETTLE_NOCHOP_CYC = SETTLE_NOCHOP_MS * CYC_PER_MS;
  localparam int          CONV_CHOP_CYC     = CONV_CHOP_MS * CYC_PER_MS;
  localparam int          SETTLE_CHOP_CYC   = SETTLE_CHOP_MS * CYC_PER_MS;
  localparam int          TIMER_W        = 26;

  typedef enum logic [1:0] {SER_CMD, SER_DATA, SER_IDLE} acr_ser_t;
endpackage

// ==== tb/acr_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// host end of the four-wire port; sclk idles high and stands still between frames
module acr_host_model (
  input  wire logic mclk,
  input  wire logic dout,
  output var  logic sclk,
  output var  logic csN,
  output var  logic din
);
  // idle levels before the first frame
  initial begin
    sclk = 1'b1;
    csN  = 1'b1;
    din  = 1'b0;
  end

  // one frame, command then data, msb first; fewer than 32 bits aborts the frame
  task automatic xfer(input logic [7:0] cmd, input logic [23:0] wr, input int ph, input int nbits,
                      output logic [23:0] rd);
    logic [31:0] sh;
    sh = {cmd, wr};
    rd = 24'h0;
    @(negedge mclk) csN = 1'b0;
    repeat (ph) @(negedge mclk);
    for (int i = 0; i < nbits; i++) begin
      sclk = 1'b0;
      din  = sh[31 - i];
      repeat (ph) @(negedge mclk);
      // sample on the rise like a real host; the last bit is gone soon after its rise
      if (i >= 8) rd = {rd[22:0], dout};
      sclk = 1'b1;
      repeat (ph) @(negedge mclk);
    end
    repeat (ph) @(negedge mclk);
    csN = 1'b1;
    din = ~din; // released line must not look like held data
  endtask
endmodule // acr_host_model
`default_nettype wire

// ==== tb/adc_configuration_register_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module adc_configuration_register_tb;
  import acr_pkg::*;
  // short timer values so settling fits in a short run
  localparam int unsigned CN = 20, SN = 80, CC = 40, SC = 160;
  logic       mclk, rst, sclk, csN, din, dout, chopEnable, referenceSourceSelect;
  logic       firstReferencePairActive, secondReferencePairActive, pseudoInputMode, shortSelect;
  logic       temperatureSelect, burnoutEnable, referenceMissingDetectEnable, bufferEnable;
  logic       unipolarMode, settled, conversionValid, settledQ;
  logic [7:0] channelEnableBits;
  logic [2:0] gainCode;
  logic [23:0] expCfg;
  int         num_errors, n_tests, cyc, fallAt;
  int         pulses[$];
  // reserved positions read back as zero on the field outputs
  wire logic [23:0] obs = {chopEnable, 2'h0, referenceSourceSelect, 1'h0, pseudoInputMode, shortSelect,
    temperatureSelect, channelEnableBits, burnoutEnable, referenceMissingDetectEnable, 1'h0, bufferEnable,
    unipolarMode, gainCode};

  acr_config_reg #(.CONV_NOCHOP(CN), .SETTLE_NOCHOP(SN), .CONV_CHOP(CC), .SETTLE_CHOP(SC)) i_acr_config_reg (
    .mclk, .rst, .sclk, .csN, .din, .dout, .chopEnable, .referenceSourceSelect, .firstReferencePairActive,
    .secondReferencePairActive, .pseudoInputMode, .shortSelect, .temperatureSelect, .channelEnableBits,
    .burnoutEnable, .referenceMissingDetectEnable, .bufferEnable, .unipolarMode, .gainCode, .settled,
    .conversionValid);
  acr_host_model i_acr_host_model (.mclk, .dout, .sclk, .csN, .din);

  // 250 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // timestamps of settling restarts and conversion pulses
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    settledQ <= settled;
    if (conversionValid === 1'b1) pulses.push_back(cyc);
    if (settled !== 1'b1 && settledQ === 1'b1) fallAt = cyc;
  end

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] cmd, input logic [23:0] d, input int ph, input int nb);
    logic [23:0] rd;
    i_acr_host_model.xfer(cmd, d, ph, nb, rd);
    repeat (4) @(negedge mclk);
  endtask

  // read back and compare with the bench copy and with every field output
  task automatic rdchk(input int ph);
    logic [23:0] rd;
    i_acr_host_model.xfer(8'h50, 24'h0, ph, 32, rd);
    repeat (4) @(negedge mclk);
    check(rd, expCfg);
    check(obs, expCfg & 24'h97FFDF);
    check({23'h0, firstReferencePairActive}, {23'h0, ~expCfg[BIT_REF_SOURCE]});
    check({23'h0, secondReferencePairActive}, {23'h0, expCfg[BIT_REF_SOURCE]});
    check({23'h0, dout}, 24'h0);
  endtask

  // a write restarts settling; first pulse after the full settling time, then one per conversion
  task automatic timing(input logic chop, input int unsigned st, input int unsigned cv);
    logic [23:0] d;
    d = {chop, 23'h10FF9F} & 24'h97FFDF;
    for (int w = 0; w < 2000 && settled !== 1'b1; w++) @(negedge mclk);
    wr(8'h10, d, 4, 32);
    // conversions keep pulsing during the frame, so count only from here
    pulses.delete();
    expCfg = d;
    check({23'h0, settled}, 24'h0);
    for (int w = 0; w < 2000 && pulses.size() < 2; w++) @(negedge mclk);
    check({23'h0, pulses.size() >= 2}, 24'h1);
    if (pulses.size() >= 2) begin
      check({23'h0, (pulses[0] - fallAt) inside {[st - 1 : st + 1]}}, 24'h1);
      check(24'(pulses[1] - pulses[0]), 24'(cv));
    end
    rdchk(4);
    $display("test timing chop=%0d done", chop);
  endtask

  task automatic tally_and_finish();
    $display("comparisons=%0d mismatches=%0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    logic [23:0] d;
    int ph;
    rst = 1'b1;
    num_errors = 0;
    n_tests = 0;
    cyc = 0;
    fallAt = 0;
    expCfg = CFG_RESET;
    void'($urandom(32'hF0D87EDF));
    repeat (12) @(negedge mclk);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    rdchk(4);
    $display("test reset done");
    for (int k = 0; k < 6; k++) begin
      d = $urandom() & 24'h97FFDF;
      ph = 4 + k % 4;
      wr(8'h10, d, ph, 32);
      expCfg = d;
      rdchk(ph);
    end
    $display("test write readback done");
    // bad write-enable, wrong select and an aborted frame leave the register alone
    wr(8'h90, ~expCfg & 24'h97FFDF, 4, 32);
    rdchk(4);
    wr(8'h18, ~expCfg & 24'h97FFDF, 5, 32);
    rdchk(4);
    wr(8'h10, ~expCfg & 24'h97FFDF, 4, 20);
    rdchk(4);
    $display("test refused frames done");
    // a reset in mid-run brings back the power-on value
    @(negedge mclk) rst = 1'b1;
    repeat (4) @(negedge mclk);
    rst = 1'b0;
    expCfg = CFG_RESET;
    repeat (4) @(negedge mclk);
    rdchk(4);
    $display("test mid-run reset done");
    timing(1'b0, SN, CN);
    timing(1'b1, SC, CC);
    tally_and_finish();
  end

  // watchdog, well beyond the expected run length
  initial begin
    repeat (60000) @(posedge mclk);
    num_errors++;
    tally_and_finish();
  end
endmodule // adc_configuration_register_tb
`default_nettype wire
